// [slrs_pkg.sv]
// Package of constants and types for the serial link run supervisor
`default_nettype none
package slrs_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00; // Mode, reaction, commands
   localparam logic [7:0] OFF_INSP_SPD = 8'h04; // Inspection speed, 0.1 ft/min
   localparam logic [7:0] OFF_CRP_SPD = 8'h08; // Rescue creep speed, 0.1 ft/min
   localparam logic [7:0] OFF_CRP_LIM = 8'h0c; // Rescue creep limit, 0.1 s
   localparam logic [7:0] OFF_TIMEOUT = 8'h10; // Link fault timeout, 0.01 s
   localparam logic [7:0] OFF_STATUS = 8'h14; // Live state, read only
   localparam logic [7:0] OFF_EVT = 8'h18; // Sticky events, read only
   localparam logic [7:0] OFF_EVT_CLR = 8'h1c; // Write one to clear
   localparam logic [7:0] OFF_EVT_EN = 8'h20; // Interrupt enables
   localparam logic [7:0] OFF_SPEED = 8'h24; // Applied speed reference
   // ==========================================
   // Control register fields
   localparam int CTRL_MODE_LO = 0; // Serial mode, 2 bits
   localparam int CTRL_REACT = 2; // Fault reaction: 1 = rescue
   localparam int CTRL_RUN = 3; // Run requested
   localparam int CTRL_INSP = 4; // Inspection requested
   localparam int CTRL_DECEL_DONE = 5; // Speed reached creep
   localparam int CTRL_MAIN_SPD_LO = 8; // Normal run speed, 16 bits
   localparam logic [1:0] SER_MODE_CUSTOM = 2'h2; // Custom serial protocol
   // ==========================================
   // Reset values and maxima in setting units
   localparam logic [15:0] INSP_SPD_RST = 16'h012c; // 30.0 ft/min
   localparam logic [15:0] INSP_SPD_MAX = 16'h03e8; // 100.0 ft/min
   localparam logic [15:0] CRP_SPD_RST = 16'h0064; // 10.0 ft/min
   localparam logic [15:0] CRP_SPD_MAX = 16'h0bb8; // 300.0 ft/min
   localparam logic [15:0] CRP_LIM_RST = 16'h0708; // 180.0 s
   localparam logic [15:0] CRP_LIM_MAX = 16'h07d0; // 200.0 s
   localparam logic [15:0] TIMEOUT_RST = 16'h0032; // 0.50 s
   localparam logic [15:0] TIMEOUT_MAX = 16'h00c8; // 2.00 s
   // ==========================================
   // Timing: tick periods in ns, converted to clock cycles
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK10MS_NS = 10000000; // Timeout unit
   localparam int TICK100MS_NS = 100000000; // Creep limit unit
   localparam int TICK10MS_CYC = TICK10MS_NS / CLK_PERIOD_NS;
   localparam int TICK100MS_CYC = TICK100MS_NS / CLK_PERIOD_NS;
   // ==========================================
   // Event bits
   localparam int EVT_FAULT = 0; // Serial fault declared
   localparam int EVT_CRP_END = 1; // Creep time expired
   localparam int EVT_W = 2;
   // ==========================================
   // Supervisor states, Gray along idle-run-decel-creep-stopped
   typedef enum logic [2:0]
   {
      SLRS_IDLE = 3'b000,
      SLRS_RUN = 3'b001,
      SLRS_DECEL = 3'b011,
      SLRS_CREEP = 3'b010,
      SLRS_STOP = 3'b110
   } slrs_state_t;
endpackage
`default_nettype wire

// [slrs_tick_if.sv]
// Interface carrying a tick counter's controls and outputs
`default_nettype none
interface slrs_tick_if;
   logic clear; // Restart count
   logic tick; // Period elapsed pulse
   logic [15:0] ticks; // Elapsed periods
   modport owner (output clear, input tick, input ticks);
   modport timer (input clear, output tick, output ticks);
endinterface
`default_nettype wire

// [slrs_tick_timer.sv]
// Prescaled elapsed-time counter used for both supervisor timers
`default_nettype none
module slrs_tick_timer #(
   parameter int PERIOD_CYC = 2500000
) (
   input wire logic clk,
   input wire logic rst_n,
   slrs_tick_if.timer tif
);
   import slrs_pkg::*;
   logic [31:0] pre_q, pre_d; // Prescaler
   logic [15:0] cnt_q, cnt_d; // Elapsed periods
   logic tick_q, tick_d; // Period pulse
   localparam logic [31:0] PRE_LAST = 32'(PERIOD_CYC - 1);
   // ==========================================
   // Next count; saturates so a long wait never wraps back to zero
   always_comb
   begin
      pre_d = pre_q + 32'h1;
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (tif.clear)
      begin
         pre_d = '0;
         cnt_d = '0;
      end
      else if (pre_q == PRE_LAST)
      begin
         pre_d = '0;
         tick_d = 1'b1;
         if (cnt_q != 16'hffff)
            cnt_d = cnt_q + 16'h1;
      end
   end
   // Registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_q <= '0;
         cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign tif.tick = tick_q;
   assign tif.ticks = cnt_q;
endmodule // slrs_tick_timer
`default_nettype wire

// [slrs_supervisor.sv]
// Top of the serial link run supervisor with its APB register file
`default_nettype none
// Function
// - Settings apply only in serial mode two
// - Inspection needs serial request and enable input
// - Inspection speed 0-100.0, default 30.0
// - Rescue creep speed 0-300.0, default 10.0
// - Creep time limited, 0-200.0 s, default 180.0
// - Creep timer excludes deceleration to creep
// - Fault when message gap exceeds timeout
module slrs_supervisor #(
   parameter int TICK_GAP_CYC = slrs_pkg::TICK10MS_CYC,
   parameter int TICK_CRP_CYC = slrs_pkg::TICK100MS_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic run_msg_valid,
   input wire logic inspection_enable_input,
   output logic [15:0] speed_ref,
   output logic drive_run,
   output logic link_fault,
   output logic irq
);
   import slrs_pkg::*;
   // ==========================================
   // Registers and state
   logic [15:0] ctrl_q, ctrl_d; // Control bits
   logic [15:0] main_spd_q, main_spd_d; // Normal run speed
   logic [15:0] inspection_speed_setting_q, inspection_speed_setting_d;
   logic [15:0] rescue_creep_speed_q, rescue_creep_speed_d;
   logic [15:0] rescue_creep_limit_q, rescue_creep_limit_d;
   logic [15:0] link_fault_timeout_q, link_fault_timeout_d;
   logic [EVT_W-1:0] evt_q, evt_d; // Sticky events
   logic [EVT_W-1:0] evt_en_q, evt_en_d; // Event enables
   logic [31:0] prdata_q, prdata_d; // Read data register
   logic [15:0] speed_q, speed_d; // Applied speed
   slrs_state_t st_q, st_d; // Supervisor state
   logic wr, rd; // Access phase strobes
   // Read data is latched on the first access edge, so the answer waits one cycle
   logic acc_q; // Wait state served, answer due
   logic mode2, run_req, insp_req, rescue, decel_done;
   logic gap_fault, crp_over; // Timer expiries
   logic [EVT_W-1:0] evt_set; // Event pulses
   slrs_tick_if gap_if ();
   slrs_tick_if crp_if ();
   // ==========================================
   // Timers: message gap in 10 ms, creep time in 100 ms
   slrs_tick_timer #(.PERIOD_CYC(TICK_GAP_CYC)) u_gap (
      .clk(clk),
      .rst_n(rst_n),
      .tif(gap_if)
   );
   slrs_tick_timer #(.PERIOD_CYC(TICK_CRP_CYC)) u_crp (
      .clk(clk),
      .rst_n(rst_n),
      .tif(crp_if)
   );
   // ==========================================
   // Decoded control
   // Write lands only on the edge where pready is high
   assign wr = psel && penable && pwrite && acc_q;
   // Read word captured once, then stands while pready is high
   assign rd = psel && penable && !pwrite && !acc_q;
   assign mode2 = (ctrl_q[CTRL_MODE_LO +: 2] == SER_MODE_CUSTOM);
   assign run_req = ctrl_q[CTRL_RUN];
   assign insp_req = ctrl_q[CTRL_INSP];
   assign rescue = ctrl_q[CTRL_REACT];
   assign decel_done = ctrl_q[CTRL_DECEL_DONE];
   assign gap_if.clear = run_msg_valid || !mode2 || (st_q != SLRS_RUN);
   assign gap_fault = (st_q == SLRS_RUN) && (gap_if.ticks > link_fault_timeout_q);
   assign crp_if.clear = (st_q != SLRS_CREEP);
   assign crp_over = (st_q == SLRS_CREEP) && (crp_if.ticks >= rescue_creep_limit_q);
   // ==========================================
   // Supervisor state machine and speed selection
   always_comb
   begin
      st_d = st_q;
      evt_set = '0;
      speed_d = '0;
      unique case (st_q)
         SLRS_IDLE:
         begin
            if (mode2 && run_req)
               st_d = SLRS_RUN;
         end
         SLRS_RUN:
         begin
            if (insp_req && inspection_enable_input)
               speed_d = inspection_speed_setting_q;
            else if (!insp_req)
               speed_d = main_spd_q;
            if (!mode2 || !run_req)
               st_d = SLRS_IDLE;
            else if (gap_fault)
            begin
               evt_set[EVT_FAULT] = 1'b1;
               st_d = rescue ? SLRS_DECEL : SLRS_STOP;
            end
         end
         SLRS_DECEL:
         begin
            // Held at creep target while the ramp settles
            speed_d = rescue_creep_speed_q;
            if (!mode2)
               st_d = SLRS_IDLE;
            else if (decel_done)
               st_d = SLRS_CREEP;
         end
         SLRS_CREEP:
         begin
            speed_d = rescue_creep_speed_q;
            if (!mode2)
               st_d = SLRS_IDLE;
            else if (crp_over)
            begin
               evt_set[EVT_CRP_END] = 1'b1;
               st_d = SLRS_STOP;
            end
         end
         SLRS_STOP:
         begin
            // Leaves only once run is withdrawn or mode two is left, a deliberate restart
            if (!mode2 || !run_req)
               st_d = SLRS_IDLE;
         end
         default: st_d = SLRS_IDLE;
      endcase
   end
   // ==========================================
   // Register file next values; settings clamp to their ranges
   always_comb
   begin
      ctrl_d = ctrl_q;
      main_spd_d = main_spd_q;
      inspection_speed_setting_d = inspection_speed_setting_q;
      rescue_creep_speed_d = rescue_creep_speed_q;
      rescue_creep_limit_d = rescue_creep_limit_q;
      link_fault_timeout_d = link_fault_timeout_q;
      evt_en_d = evt_en_q;
      evt_d = evt_q;
      prdata_d = prdata_q;
      if (wr)
      begin
         unique case (paddr)
            OFF_CTRL:
            begin
               ctrl_d = pwdata[15:0];
               main_spd_d = pwdata[CTRL_MAIN_SPD_LO + 8 +: 16];
            end
            OFF_INSP_SPD: inspection_speed_setting_d =
               (pwdata[15:0] > INSP_SPD_MAX) ? INSP_SPD_MAX : pwdata[15:0];
            OFF_CRP_SPD: rescue_creep_speed_d =
               (pwdata[15:0] > CRP_SPD_MAX) ? CRP_SPD_MAX : pwdata[15:0];
            OFF_CRP_LIM: rescue_creep_limit_d =
               (pwdata[15:0] > CRP_LIM_MAX) ? CRP_LIM_MAX : pwdata[15:0];
            OFF_TIMEOUT: link_fault_timeout_d =
               (pwdata[15:0] > TIMEOUT_MAX) ? TIMEOUT_MAX : pwdata[15:0];
            OFF_EVT_CLR: evt_d = evt_q & ~pwdata[EVT_W-1:0];
            OFF_EVT_EN: evt_en_d = pwdata[EVT_W-1:0];
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      evt_d = evt_d | evt_set;
      if (rd)
      begin
         unique case (paddr)
            OFF_CTRL: prdata_d = {main_spd_q, ctrl_q};
            OFF_INSP_SPD: prdata_d = {16'h0, inspection_speed_setting_q};
            OFF_CRP_SPD: prdata_d = {16'h0, rescue_creep_speed_q};
            OFF_CRP_LIM: prdata_d = {16'h0, rescue_creep_limit_q};
            OFF_TIMEOUT: prdata_d = {16'h0, link_fault_timeout_q};
            OFF_STATUS: prdata_d = {13'h0, st_q, gap_if.ticks};
            OFF_EVT: prdata_d = {30'h0, evt_q};
            OFF_EVT_EN: prdata_d = {30'h0, evt_en_q};
            OFF_SPEED: prdata_d = {16'h0, speed_q};
            default: prdata_d = '0;
         endcase
      end
   end
   // ==========================================
   // All registers except acc_q
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= '0;
         main_spd_q <= '0;
         inspection_speed_setting_q <= INSP_SPD_RST;
         rescue_creep_speed_q <= CRP_SPD_RST;
         rescue_creep_limit_q <= CRP_LIM_RST;
         link_fault_timeout_q <= TIMEOUT_RST;
         evt_q <= '0;
         evt_en_q <= '0;
         prdata_q <= '0;
         speed_q <= '0;
         st_q <= SLRS_IDLE;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         main_spd_q <= main_spd_d;
         inspection_speed_setting_q <= inspection_speed_setting_d;
         rescue_creep_speed_q <= rescue_creep_speed_d;
         rescue_creep_limit_q <= rescue_creep_limit_d;
         link_fault_timeout_q <= link_fault_timeout_d;
         evt_q <= evt_d;
         evt_en_q <= evt_en_d;
         prdata_q <= prdata_d;
         speed_q <= speed_d;
         st_q <= st_d;
      end
   end
   // ==========================================
   // Outputs; one wait state keeps read data registered
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         acc_q <= 1'b0;
      else
         acc_q <= psel && penable && !acc_q;
   end
   assign pready = acc_q;
   assign pslverr = 1'b0;
   assign prdata = prdata_q;
   assign speed_ref = speed_q;
   assign drive_run = (st_q == SLRS_RUN) || (st_q == SLRS_DECEL) || (st_q == SLRS_CREEP);
   assign link_fault = (st_q == SLRS_DECEL) || (st_q == SLRS_CREEP) || (st_q == SLRS_STOP);
   assign irq = |(evt_q & evt_en_q);
endmodule // slrs_supervisor
`default_nettype wire

// [slrs_chk_assertions.sv]
// Port checker for the serial link run supervisor
`default_nettype none
module slrs_chk #(
   parameter int TICK_GAP_CYC = 10,
   parameter int TICK_CRP_CYC = 20
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic run_msg_valid,
   input wire logic [15:0] speed_ref,
   input wire logic drive_run,
   input wire logic link_fault,
   input wire logic irq
);
   // ==========================================
   // Cycles since last message or run entry
   int gap_q; // Registered count
   int gap_d; // Next count
   // Cleared by a message or while drive_run is low, so it keeps counting in decel and creep
   always_comb
   begin
      gap_d = (run_msg_valid || !drive_run) ? 0 : gap_q + 1;
   end
   // Count register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap_q <= 0;
      end
      else
      begin
         gap_q <= gap_d;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_ready; psel && penable && !pready |=> pready && !pslverr; endproperty
   a_ready: assert property (p_ready) else $error("apb answer not after one wait");
   property p_fault_src; $rose(link_fault) |-> $past(drive_run); endproperty
   a_fault_src: assert property (p_fault_src) else $error("fault outside run");
   property p_gap; $rose(link_fault) |-> $past(gap_q) >= TICK_GAP_CYC - 2; endproperty
   a_gap: assert property (p_gap) else $error("fault before one tick gap");
   property p_leave; $fell(link_fault) |-> !drive_run && $past(!drive_run); endproperty
   a_leave: assert property (p_leave) else $error("fault left while moving");
   property p_irq; $rose(irq) |-> link_fault || $past(psel && penable && pwrite); endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");
   property p_idle; !drive_run && $past(!drive_run) && !link_fault |-> speed_ref == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("speed while idle");
   property p_stop; link_fault && !drive_run && $past(!drive_run) |-> speed_ref == 16'h0000;
   endproperty
   a_stop: assert property (p_stop) else $error("speed while stopped");
   property p_start; $rose(drive_run) |-> !link_fault ##1 !$rose(link_fault); endproperty
   a_start: assert property (p_start) else $error("run entered faulted");
   // Main scenarios seen
   c_fault: cover property ($rose(link_fault));
   c_irq: cover property ($rose(irq));
   c_creep_end: cover property ($fell(drive_run) && link_fault && gap_q < TICK_CRP_CYC);
endmodule // slrs_chk
bind slrs_supervisor slrs_chk #(.TICK_GAP_CYC(TICK_GAP_CYC), .TICK_CRP_CYC(TICK_CRP_CYC))
   i_slrs_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .run_msg_valid(run_msg_valid), .speed_ref(speed_ref),
   .drive_run(drive_run), .link_fault(link_fault), .irq(irq));
`default_nettype wire

// [slrs_ctrl_model.sv]
// Motion controller model sending periodic run messages
`default_nettype none
module slrs_ctrl_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic active,
   input wire logic [7:0] gap,
   output logic run_msg_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt; // Cycles since last message
   // one pulse per gap plus one cycles, silent when inactive
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n || !active)
      begin
         cnt <= 8'h00;
         run_msg_valid <= 1'b0;
      end
      else
      begin
         cnt <= (cnt >= gap) ? 8'h00 : cnt + 8'h01;
         run_msg_valid <= (cnt >= gap);
      end
   end
endmodule // slrs_ctrl_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the serial link run supervisor
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import slrs_pkg::*;
   localparam int GAP = 10; // Short gap tick
   localparam int CRP = 20; // Short creep tick
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ins_en = 0, msg_on = 0;
   logic [7:0] paddr = 8'h00, msg_gap = 8'h04;
   logic [31:0] pwdata = 32'h0, prdata, v, rdat;
   logic pready, pslverr, msg, drive_run, link_fault, irq;
   logic [15:0] speed_ref, r, b;
   logic [7:0] offs [4] = '{OFF_INSP_SPD, OFF_CRP_SPD, OFF_CRP_LIM, OFF_TIMEOUT};
   logic [15:0] rstv [4] = '{INSP_SPD_RST, CRP_SPD_RST, CRP_LIM_RST, TIMEOUT_RST};
   logic [15:0] maxv [4] = '{INSP_SPD_MAX, CRP_SPD_MAX, CRP_LIM_MAX, TIMEOUT_MAX};
   int miscompares = 0, n_tests = 0, n;
   // ==========================================
   // Clock, design and far side
   always #2 clk = ~clk;
   slrs_supervisor #(.TICK_GAP_CYC(GAP), .TICK_CRP_CYC(CRP)) i_slrs_supervisor (.clk(clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .run_msg_valid(msg), .inspection_enable_input(ins_en), .speed_ref(speed_ref),
      .drive_run(drive_run), .link_fault(link_fault), .irq(irq));
   slrs_ctrl_model i_slrs_ctrl_model (.clk(clk), .rst_n(rst_n), .active(msg_on),
      .gap(msg_gap), .run_msg_valid(msg));
   // ==========================================
   // Shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Bounded wait ran out: fail the run
   task automatic tmo(input int cnt, input int lim);
      if (cnt >= lim)
      begin
         miscompares++;
         results();
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         // Read data taken at the very edge where pready is seen high
         if (pready === 1'b1)
         begin
            rdat = prdata;
            break;
         end
      end
      tmo(k, 50);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One read; the word is the one standing when pready was high
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      xfer(1'b0, a, 32'h0);
      d = rdat;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // Control word; speed byte repeated so either speed field reads alike
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [3:0] f);
      return {b[7:0], b[7:0], b[7:0], 2'b00, f, m};
   endfunction
   function automatic logic [15:0] clampv(input logic [15:0] x, input logic [15:0] mx);
      return (x > mx) ? mx : x;
   endfunction
   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h8fdb));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      b = {2{8'($urandom_range(1, 255))}};
      for (int i = 0; i < 4; i++)
      begin
         rd(offs[i], v);
         check("reset value", v, {16'h0, rstv[i]});
         r = 16'($urandom_range(0, 65535));
         xfer(1'b1, offs[i], {16'h0, (i[0] ? 16'hffff : r)});
         rd(offs[i], v);
         check("setting", v, {16'h0, clampv(i[0] ? 16'hffff : r, maxv[i])});
      end
      rd(8'h3c, v);
      check("unmapped", v, 32'h0);
      $display("test settings done");
      // Normal run, then silence with stop reaction
      xfer(1'b1, OFF_TIMEOUT, 32'h2);
      xfer(1'b1, OFF_EVT_EN, 32'h3);
      msg_on <= 1'b1;
      xfer(1'b1, OFF_CTRL, ctl(SER_MODE_CUSTOM, 4'b0010));
      cyc(100);
      check("run", {link_fault, drive_run, speed_ref}, {2'b01, b});
      @(posedge clk) msg_on <= 1'b0;
      for (n = 0; n < 200 && link_fault !== 1'b1; n++) @(posedge clk);
      tmo(n, 200);
      check("gap window", n >= 20 && n <= 45, 1'b1);
      cyc(2);
      check("stop reaction", {drive_run, irq}, 2'b01);
      rd(OFF_EVT, v);
      check("fault event", v, 32'h1);
      xfer(1'b1, OFF_EVT_CLR, 32'h1);
      cyc(2);
      check("irq clear", irq, 1'b0);
      xfer(1'b1, OFF_CTRL, ctl(SER_MODE_CUSTOM, 4'b0000));
      cyc(3);
      check("idle", link_fault, 1'b0);
      $display("test stop done");
      // Rescue: decel excluded from creep time, creep bounded
      r = 16'($urandom_range(0, 3000));
      xfer(1'b1, OFF_CRP_SPD, {16'h0, r});
      xfer(1'b1, OFF_CRP_LIM, 32'h3);
      msg_on <= 1'b1;
      xfer(1'b1, OFF_CTRL, ctl(SER_MODE_CUSTOM, 4'b0011));
      cyc(50);
      @(posedge clk) msg_on <= 1'b0;
      for (n = 0; n < 200 && link_fault !== 1'b1; n++) @(posedge clk);
      tmo(n, 200);
      cyc(100);
      check("decel holds", drive_run, 1'b1);
      xfer(1'b1, OFF_CTRL, ctl(SER_MODE_CUSTOM, 4'b1011));
      cyc(3);
      check("creep speed", speed_ref, r);
      for (n = 0; n < 300 && drive_run !== 1'b0; n++) @(posedge clk);
      tmo(n, 300);
      check("creep limit", n >= 40 && n <= 80, 1'b1);
      rd(OFF_EVT, v);
      check("creep event", v, 32'h3);
      xfer(1'b1, OFF_EVT_CLR, 32'h3);
      xfer(1'b1, OFF_CTRL, ctl(SER_MODE_CUSTOM, 4'b0000));
      $display("test rescue done");
      // Inspection needs both sources; mode one ignores settings
      r = 16'($urandom_range(1, 1000));
      xfer(1'b1, OFF_INSP_SPD, {16'h0, r});
      msg_on <= 1'b1;
      xfer(1'b1, OFF_CTRL, ctl(SER_MODE_CUSTOM, 4'b0110));
      cyc(20);
      check("insp no enable", speed_ref, 16'h0);
      @(posedge clk) ins_en <= 1'b1;
      cyc(5);
      check("insp speed", speed_ref, r);
      rd(OFF_SPEED, v);
      check("speed reg", v, {16'h0, r});
      @(posedge clk) msg_on <= 1'b0;
      xfer(1'b1, OFF_CTRL, ctl(2'h1, 4'b0110));
      cyc(100);
      check("mode one", {link_fault, speed_ref == r}, 2'b00);
      $display("test inspection done");
      results();
   end
   // Overall hang guard
   initial
   begin
      #400000;
      tmo(1, 1);
   end
endmodule // testbench
`default_nettype wire
